// ---- hdl/spo_pkg.sv ----
// shared constants and carrier types for the sample output port
// assumes one system clock; converter clock arrives as a plain pin
package spo_pkg;
    localparam int unsigned WORD_W      = 10;
    localparam int unsigned MSB_BIT     = WORD_W - 1;
    localparam int unsigned STAMP_W     = 4;
    localparam int unsigned MEM_AW      = 3;
    localparam int unsigned FILL_W      = 3;
    // rising edges between a sample's start and its read-out
    localparam logic [FILL_W-1:0]  SAMPLE_LAG  = 3'h6;
    // latency 6.5 converter clocks, counted in half steps
    localparam logic [STAMP_W-1:0] LAT_HALF    = 4'hd;
    localparam logic [STAMP_W-1:0] HALF_PER_CK = 4'h2;
    localparam logic [STAMP_W-1:0] STAMP_RST   = 4'h0;
    localparam logic [MEM_AW-1:0]  PTR_RST     = 3'h0;
    localparam logic [FILL_W-1:0]  FILL_RST    = 3'h0;
    localparam logic [WORD_W-1:0]  WORD_RST    = 10'h000;

    typedef struct packed {
        logic [WORD_W-1:0]  code;
        logic [STAMP_W-1:0] stamp;
    } spo_sample_type;

    localparam int unsigned SAMPLE_W = WORD_W + STAMP_W;
    localparam spo_sample_type SAMPLE_RST = '{code: WORD_RST, stamp: STAMP_RST};

    typedef enum logic [1:0] {
        SPO_EMPTY = 2'b00,
        SPO_ONE   = 2'b01,
        SPO_TWO   = 2'b10
    } spo_occ_type;
endpackage : spo_pkg

// ---- hdl/spo_delay_mem.sv ----
// small ring memory that holds samples while they walk the pipeline
// assumes one write and one read per cycle at most; read data registered
`timescale 1ns/1ns
module spo_delay_mem #(
    parameter int unsigned DW = 14,
    parameter int unsigned AW = 3
) (
    // clock
    input  wire logic          clk_sys,
    // write side
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    // read side
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);
    logic [DW-1:0] mem [2**AW];

    // no reset: the read port loads every cycle, but no word is used before it is written
    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule : spo_delay_mem

// ---- hdl/spo_port.sv ----
// digital output side of a pipelined sampling converter
// assumes conv_clk is slower than clk_sys/4 and quant_word is on clk_sys
`timescale 1ns/1ns
module spo_port
    import spo_pkg::*;
(
    // clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       reset_n,
    // converter pins
    input  wire logic                       conv_clk,
    input  wire logic                       coding_sel,
    input  wire logic                       output_enable_n,
    // quantizer result at each conversion start
    input  wire logic [spo_pkg::WORD_W-1:0] quant_word,
    // sample word outputs
    output logic      [spo_pkg::WORD_W-1:0] data_out,
    output logic      [spo_pkg::WORD_W-1:0] data_oe,
    output logic                            out_valid,
    input  wire logic                       out_ready,
    output logic                            overrun
);
    // pin synchronisers; stage one feeds only stage two
    logic ck_s1, ck_s2, ck_s3;
    logic sel_s1, sel_s2;
    logic oen_s1, oen_s2;

    always_ff @(posedge clk_sys) begin
        ck_s1  <= conv_clk;
        ck_s2  <= ck_s1;
        ck_s3  <= ck_s2;
        sel_s1 <= coding_sel;
        sel_s2 <= sel_s1;
        oen_s1 <= output_enable_n;
        oen_s2 <= oen_s1;
    end

    wire rise = ck_s2 & ~ck_s3;
    wire fall = ~ck_s2 & ck_s3;
    wire step = rise | fall;

    logic [STAMP_W-1:0] half_count;
    logic [MEM_AW-1:0]  wr_ptr;
    logic [FILL_W-1:0]  fill;
    logic               rd_issued;
    logic               pend_valid;
    spo_sample_type     pend;
    logic [SAMPLE_W-1:0] rd_raw;

    wire primed = (fill == SAMPLE_LAG);
    wire [MEM_AW-1:0] rd_addr = wr_ptr - MEM_AW'(SAMPLE_LAG);
    wire spo_sample_type wr_word = '{code: quant_word, stamp: half_count};

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            half_count <= STAMP_RST;
            wr_ptr     <= PTR_RST;
            fill       <= FILL_RST;
            rd_issued  <= 1'b0;
        end else begin
            if (step) begin
                half_count <= half_count + 1'b1;
            end
            if (rise) begin
                wr_ptr <= wr_ptr + 1'b1;
                if (!primed) begin
                    fill <= fill + 1'b1;
                end
            end
            rd_issued <= rise & primed;
        end
    end

    spo_delay_mem #(
        .DW (SAMPLE_W),
        .AW (MEM_AW)
    ) u_mem (
        .clk_sys (clk_sys),
        .wr_en   (rise),
        .wr_addr (wr_ptr),
        .wr_data (wr_word),
        .rd_addr (rd_addr),
        .rd_data (rd_raw)
    );

    // coding applied as the word is fetched; select is static in use
    wire [WORD_W-1:0] rd_code  = rd_raw[SAMPLE_W-1:STAMP_W];
    wire [WORD_W-1:0] coded    = sel_s2 ? {~rd_code[MSB_BIT], rd_code[MSB_BIT-1:0]}
                                        : rd_code;

    // two-entry buffer
    spo_occ_type    occ, next_occ;
    spo_sample_type slot1, next_slot1, head, next_head;

    wire in_ready = (occ != SPO_TWO);
    wire push     = fall & pend_valid & in_ready;
    wire pop      = out_valid & out_ready;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            pend_valid <= 1'b0;
            pend       <= SAMPLE_RST;
            overrun    <= 1'b0;
        end else begin
            if (rd_issued) begin
                pend_valid <= 1'b1;
                pend       <= '{code: coded, stamp: rd_raw[STAMP_W-1:0]};
            end else if (fall) begin
                pend_valid <= 1'b0;
            end
            // a receiver stalled for two words loses the next one
            if (fall & pend_valid & ~in_ready) begin
                overrun <= 1'b1;
            end
        end
    end

    always_comb begin
        next_occ   = occ;
        next_head  = head;
        next_slot1 = slot1;
        case (occ)
            SPO_EMPTY: begin
                if (push) begin
                    next_head = pend;
                    next_occ  = SPO_ONE;
                end
            end
            SPO_ONE: begin
                if (push && pop) begin
                    next_head = pend;
                end else if (push) begin
                    next_slot1 = pend;
                    next_occ   = SPO_TWO;
                end else if (pop) begin
                    next_occ = SPO_EMPTY;
                end
            end
            SPO_TWO: begin
                if (pop) begin
                    next_head = slot1;
                    next_occ  = SPO_ONE;
                end
            end
            default: begin
                next_occ = SPO_EMPTY;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            occ       <= SPO_EMPTY;
            head      <= SAMPLE_RST;
            slot1     <= SAMPLE_RST;
            out_valid <= 1'b0;
            data_out  <= WORD_RST;
            data_oe   <= WORD_RST;
        end else begin
            occ       <= next_occ;
            head      <= next_head;
            slot1     <= next_slot1;
            out_valid <= (next_occ != SPO_EMPTY);
            data_out  <= next_head.code;
            data_oe   <= {WORD_W{~oen_s2}};
        end
    end

    // helpers for checking
    logic [STAMP_W-1:0] last_stamp;
    logic               seen_push;
    wire  [STAMP_W-1:0] age = half_count - pend.stamp;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            last_stamp <= STAMP_RST;
            seen_push  <= 1'b0;
        end else if (push) begin
            last_stamp <= pend.stamp;
            seen_push  <= 1'b1;
        end
    end

    // reset_n in the antecedent keeps the release edge, where the counter is still held, out
    AST_STEP_BOTH_EDGES: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (reset_n && (ck_s2 != ck_s3)) |=> (half_count == $past(half_count) + 1'b1))
        else $error("half step missed on a converter clock edge");

    AST_LATENCY: assert property (@(posedge clk_sys) disable iff (!reset_n)
        push |-> (age == LAT_HALF))
        else $error("word released at wrong latency");

    AST_SOB: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (rd_issued && !sel_s2) |=> (pend.code == $past(rd_code)))
        else $error("offset binary word altered");

    AST_BTC: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (rd_issued && sel_s2) |=>
            (pend.code == {~$past(rd_code[MSB_BIT]), $past(rd_code[MSB_BIT-1:0])}))
        else $error("twos complement msb not inverted");

    // data_oe is still forced low at the release edge, so that attempt must be vacuous
    AST_OE: assert property (@(posedge clk_sys) disable iff (!reset_n)
        reset_n |=> (data_oe == {WORD_W{~$past(oen_s2)}}))
        else $error("output enable does not follow pin");

    AST_IN_ORDER: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (push && seen_push && !$past(overrun)) |-> (pend.stamp - last_stamp == HALF_PER_CK)
            or overrun)
        else $error("samples out of order or gapped");

    AST_HOLD_WORD: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (out_valid && !out_ready) |=> (out_valid && $stable(data_out)))
        else $error("stalled word changed or dropped");

    AST_PUSH_ON_FALL: assert property (@(posedge clk_sys) disable iff (!reset_n)
        rd_issued |-> !fall[*2])
        else $error("read issued with no room before falling edge");
endmodule : spo_port

// ---- sim/spo_capture_model.sv ----
// capture-side model: makes the converter clock and paces the receiver
// assumes clk_sys at 50 MHz; policy 0 always ready, 1 random stalls, 2 never ready
`timescale 1ns/1ns
module spo_capture_model
    import spo_pkg::*;
(
    // bench control
    input  wire logic       clk_sys,
    input  wire logic       run,
    input  wire logic [1:0] policy,
    // pins toward the block
    output logic            conv_clk,
    output logic            out_ready
);
    logic [1:0] cnt;
    initial begin
        conv_clk  = 1'b0;
        out_ready = 1'b0;
        cnt       = 2'h0;
    end
    // four cycles high, four low; a stop waits for the fall so no runt pulse
    // 6.25 MHz stays far below the rate where a duty skew would matter
    always @(posedge clk_sys) begin
        if (run || conv_clk) begin
            cnt <= cnt + 2'h1;
            if (cnt == 2'h3) conv_clk <= ~conv_clk;
        end
        out_ready <= (policy == 2'h0) || (policy == 2'h1 && $urandom_range(1, 0) == 1);
    end
endmodule : spo_capture_model

// ---- sim/spo_port_test.sv ----
// self-checking bench for the sample output port
// assumes the capture model runs the converter clock at clk_sys/8
`timescale 1ns/1ns
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin n_fail++; \
    $display("mismatch at %0t: got %h want %h", $time, got, exp); end end
module spo_port_test;
    import spo_pkg::*;
    logic              clk_sys, reset_n, coding_sel, output_enable_n, run;
    logic              conv_clk, out_valid, out_ready, overrun;
    logic [1:0]        policy;
    logic [WORD_W-1:0] quant_word, data_out, data_oe, w;
    logic [WORD_W-1:0] exp_q[$];
    int                n_fail, checks, cycles, got_n, lat, n_word;
    time               t_rise;

    spo_port u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .conv_clk(conv_clk),
        .coding_sel(coding_sel), .output_enable_n(output_enable_n),
        .quant_word(quant_word), .data_out(data_out), .data_oe(data_oe),
        .out_valid(out_valid), .out_ready(out_ready), .overrun(overrun));
    spo_capture_model u_far (.clk_sys(clk_sys), .run(run), .policy(policy),
        .conv_clk(conv_clk), .out_ready(out_ready));

    function automatic logic [WORD_W-1:0] coded(logic [WORD_W-1:0] v, logic sel);
        return sel ? (v ^ 10'h200) : v;
    endfunction : coded

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // new word each fall; every fifth word is zero, the rest are random codes
    // guarded so the time-zero settling of the pin cannot race the initial values
    always @(negedge conv_clk) begin
        if (reset_n === 1'b1) begin
            n_word++;
            quant_word <= (n_word % 5 == 0) ? 10'h000 : 10'(($urandom));
        end
    end
    always @(posedge conv_clk) begin
        exp_q.push_back(coded(quant_word, coding_sel));
        if (t_rise == 0) t_rise = $time;
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (reset_n === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1) begin
            got_n++;
            if (exp_q.size() == 0) `CHK(1'b0, 1'b1)
            else begin
                w = exp_q.pop_front();
                `CHK(data_out, w)
            end
        end
        // ceiling well above the roughly 800 cycles the tests need
        if (cycles == 5000) begin
            n_fail++;
            report_and_stop();
        end
    end

    task automatic apply_reset();
        run     <= 1'b0;
        reset_n <= 1'b0;
        repeat (16) @(posedge clk_sys);
        exp_q.delete();
        t_rise  = 0;
        got_n   = 0;
        reset_n <= 1'b1;
        repeat (2) @(posedge clk_sys);
        `CHK(out_valid, 1'b0)
        `CHK(overrun, 1'b0)
    endtask : apply_reset

    task automatic stream(input logic sel, input logic [1:0] pol, input int n);
        int k;
        coding_sel <= sel;
        policy     <= pol;
        apply_reset();
        run <= 1'b1;
        for (k = 0; k < 200 && out_valid !== 1'b1; k++) @(posedge clk_sys);
        lat = (t_rise == 0) ? 0 : int'(($time - t_rise) / 20);
        if (pol != 2'h2) `CHK(lat >= 53 && lat <= 59, 1'b1)
        repeat (n * 8) @(posedge clk_sys);
        run <= 1'b0;
        repeat (12) @(posedge clk_sys);
        if (pol != 2'h2) `CHK(got_n >= n - 8, 1'b1)
        `CHK(overrun, (pol == 2'h2))
        $display("stream sel=%0d policy=%0d words=%0d done", sel, pol, got_n);
    endtask : stream

    task automatic report_and_stop();
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    initial begin
        reset_n = 1'b0;
        run = 1'b0;
        policy = 2'h0;
        coding_sel = 1'b0;
        output_enable_n = 1'b0;
        quant_word = 10'h3ff;
        n_fail = 0;
        checks = 0;
        cycles = 0;
        n_word = 1;
        t_rise = 0;
        void'($urandom(32'h6a2a));
        stream(1'b0, 2'h0, 20);
        stream(1'b1, 2'h1, 30);
        // enable pin flipped only while the converter clock stands still
        output_enable_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        `CHK(data_oe, 10'h000)
        output_enable_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        `CHK(data_oe, 10'h3ff)
        $display("output enable test done");
        stream(1'b0, 2'h2, 12);
        report_and_stop();
    end
endmodule : spo_port_test
